// *** core/stdd_top.sv ***
// Descriptor FIFO and split transfer descriptor decoder with AHB-Lite slave
`default_nettype none

module stdd_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16,
    localparam int AW   = $clog2(DEPTH)
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data,
    output logic [AW:0]       level
);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW-1:0] next_rd;
    logic [AW-1:0] next_wr;
    logic [AW:0]   cnt;
    logic [AW:0]   next_cnt;
    logic          push;
    logic          pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = (cnt != (AW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign out_data  = mem[rd];
    assign level     = cnt;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_wr  = push ? ptr_inc(wr) : wr;
        next_rd  = pop ? ptr_inc(rd) : rd;
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop && !push) begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd  <= '0;
            wr  <= '0;
            cnt <= '0;
        end else begin
            rd  <= next_rd;
            wr  <= next_wr;
            cnt <= next_cnt;
        end
    end

    // Storage needs no reset; the count guards every read
    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr] <= in_data;
        end
    end
endmodule // stdd_fifo

////////////////////////////////////////////////////////////////////////////////

module stdd_top
    import stdd_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             xfer_start,
    output stdd_pkg::stdd_xfer_s xfer,
    input  wire logic        xfer_done,
    input  wire logic        xfer_fatal
);
    import stdd_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_GET   = 4'b0010,
        ST_ISSUE = 4'b0100,
        ST_WAIT  = 4'b1000
    } stdd_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave state
    logic        dp_pend;
    logic        next_dp_pend;
    logic        dp_write;
    logic        next_dp_write;
    logic [7:0]  dp_addr;
    logic [7:0]  next_dp_addr;
    logic        next_hreadyout;
    logic [31:0] next_hrdata;
    logic        ctrl_en;
    logic        next_ctrl_en;

    // Decoder state
    stdd_state_e state;
    stdd_state_e next_state;
    stdd_desc_s  desc;
    stdd_desc_s  next_desc;
    logic [1:0]  wcnt;
    logic [1:0]  next_wcnt;
    logic        next_xfer_start;
    stdd_xfer_s  next_xfer;
    logic [31:0] last_dw0;
    logic [31:0] next_last_dw0;
    logic [7:0]  skip_cnt;
    logic [7:0]  next_skip_cnt;
    logic        fatal_seen;
    logic        next_fatal_seen;
    logic        oversize;
    logic        next_oversize;

    // FIFO wiring
    logic          f_in_valid;
    logic          f_in_ready;
    logic          f_out_valid;
    logic [31:0]   f_out_data;
    logic          f_out_ready;
    logic [LW-1:0] f_level;
    logic          is_push;
    logic          dp_done;
    logic          addr_take;

    function automatic stdd_xfer_s decode(input stdd_desc_s d);
        stdd_xfer_s x;
        x.ep        = {d.dw1[EPH_LSB +: 3], d.dw0[EP0_BIT]};
        x.max_pkt   = d.dw0[MPL_LSB +: 11];
        x.total     = d.dw0[TOT_LSB +: 15];
        x.split     = d.dw1[SPLIT_BIT];
        // Code only counts for splits; 01 and 11 fall back to full speed
        x.low_speed = x.split && (d.dw1[SE_LSB +: 2] == SE_LOW);
        // Index is already in internal units, used as given
        x.mem_index = d.dw2[IDX_LSB +: 16];
        return x;
    endfunction

    stdd_fifo #(
        .W     (32),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (hwdata),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data),
        .level     (f_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: every transfer takes one wait state; a push into a
    // full FIFO holds hreadyout low so back-pressure reaches the master
    assign addr_take  = hsel && hready && htrans[1];
    assign is_push    = dp_write && (dp_addr == OFS_PUSH);
    assign f_in_valid = dp_pend && is_push;
    assign dp_done    = dp_pend && (!is_push || f_in_ready);

    always_comb begin
        next_dp_pend   = dp_pend;
        next_dp_write  = dp_write;
        next_dp_addr   = dp_addr;
        next_hreadyout = hreadyout;
        next_hrdata    = hrdata;
        next_ctrl_en   = ctrl_en;
        if (addr_take) begin
            next_dp_pend   = 1'b1;
            next_dp_write  = hwrite;
            next_dp_addr   = {haddr[7:2], 2'b00};
            next_hreadyout = 1'b0;
        end else if (dp_done) begin
            next_dp_pend   = 1'b0;
            next_hreadyout = 1'b1;
            next_hrdata    = 32'h0000_0000;
            if (dp_write) begin
                if (dp_addr == OFS_CTRL) begin
                    next_ctrl_en = hwdata[0];
                end
            end else begin
                case (dp_addr)
                    OFS_STATUS: next_hrdata = {16'h0000, skip_cnt,
                        fatal_seen, oversize, (state != ST_IDLE),
                        5'(f_level)};
                    OFS_LAST:   next_hrdata = last_dw0;
                    OFS_CTRL:   next_hrdata = {31'h0, ctrl_en};
                    default:    next_hrdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_pend   <= 1'b0;
            dp_write  <= 1'b0;
            dp_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            ctrl_en   <= CTRL_EN_RST;
            hresp     <= 1'b0;
        end else begin
            dp_pend   <= next_dp_pend;
            dp_write  <= next_dp_write;
            dp_addr   <= next_dp_addr;
            hreadyout <= next_hreadyout;
            hrdata    <= next_hrdata;
            ctrl_en   <= next_ctrl_en;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor decoder
    assign f_out_ready = (state == ST_GET);

    always_comb begin
        next_state      = state;
        next_desc       = desc;
        next_wcnt       = wcnt;
        next_xfer_start = 1'b0;
        next_xfer       = xfer;
        next_last_dw0   = last_dw0;
        next_skip_cnt   = skip_cnt;
        next_fatal_seen = fatal_seen;
        next_oversize   = oversize;
        case (state)
            ST_IDLE: begin
                next_wcnt = 2'h0;
                if (ctrl_en && f_out_valid) begin
                    next_state = ST_GET;
                end
            end
            ST_GET: begin
                if (f_out_valid) begin
                    case (wcnt)
                        2'h0:    next_desc.dw0 = f_out_data;
                        2'h1:    next_desc.dw1 = f_out_data;
                        default: next_desc.dw2 = f_out_data;
                    endcase
                    next_wcnt = wcnt + 2'h1;
                    if (wcnt == LAST_WORD) begin
                        next_state = ST_ISSUE;
                    end
                end
            end
            ST_ISSUE: begin
                if (desc.dw0[ACT_BIT]) begin
                    next_xfer       = decode(desc);
                    next_xfer_start = 1'b1;
                    // Flags a software slip; the transfer still runs
                    next_oversize = next_xfer.split
                        && !next_xfer.low_speed
                        && (next_xfer.max_pkt > FS_MAX_PKT);
                    next_state = ST_WAIT;
                end else begin
                    next_last_dw0 = desc.dw0;
                    next_skip_cnt = skip_cnt + 8'h01;
                    next_state    = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (xfer_done || xfer_fatal) begin
                    next_last_dw0 = desc.dw0 & ~32'h0000_0001;
                    next_fatal_seen = xfer_fatal;
                    next_state    = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state      <= ST_IDLE;
            desc       <= '0;
            wcnt       <= 2'h0;
            xfer_start <= 1'b0;
            xfer       <= '0;
            last_dw0   <= 32'h0000_0000;
            skip_cnt   <= SKIP_RST;
            fatal_seen <= 1'b0;
            oversize   <= 1'b0;
        end else begin
            state      <= next_state;
            desc       <= next_desc;
            wcnt       <= next_wcnt;
            xfer_start <= next_xfer_start;
            xfer       <= next_xfer;
            last_dw0   <= next_last_dw0;
            skip_cnt   <= next_skip_cnt;
            fatal_seen <= next_fatal_seen;
            oversize   <= next_oversize;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_endpoint_join: assert property (
        xfer_start |-> xfer.ep == {desc.dw1[EPH_LSB +: 3], desc.dw0[EP0_BIT]})
        else $error("endpoint number not joined from both words");

    a_packet_limit: assert property (
        (state == ST_ISSUE && desc.dw0[ACT_BIT])
        |=> xfer.max_pkt == $past(desc.dw0[28:18]))
        else $error("per packet limit wrong");

    a_payload_total: assert property (
        xfer_start |-> xfer.total == desc.dw0[17:3] && state == ST_WAIT)
        else $error("payload total wrong");

    a_active_clear: assert property (
        (state == ST_WAIT && (xfer_done || xfer_fatal))
        |=> !last_dw0[ACT_BIT] && state == ST_IDLE
            && last_dw0[31:1] == $past(desc.dw0[31:1]))
        else $error("active bit not cleared at end");

    a_speed_code: assert property (
        (xfer_start && xfer.split)
        |-> xfer.low_speed == (desc.dw1[SE_LSB +: 2] == SE_LOW))
        else $error("speed code misread");

    a_split_select: assert property (
        (state == ST_ISSUE && desc.dw0[ACT_BIT])
        |=> xfer_start && xfer.split == $past(desc.dw1[SPLIT_BIT])
            ##1 !xfer_start)
        else $error("split selection wrong");

    a_hs_ignore_se: assert property (
        (xfer_start && !xfer.split) |-> !xfer.low_speed)
        else $error("speed code used for high speed");

    a_skip_idle: assert property (
        (state == ST_ISSUE && !desc.dw0[ACT_BIT])
        |=> !xfer_start && state == ST_IDLE
            && skip_cnt == 8'($past(skip_cnt) + 8'h01))
        else $error("inactive descriptor not skipped");

    c_low_split: cover property (xfer_start && xfer.split && xfer.low_speed);
    c_hs_xfer:   cover property (xfer_start && !xfer.split);
    c_skip:      cover property (state == ST_ISSUE && !desc.dw0[ACT_BIT]);
    c_stall:     cover property (dp_pend && is_push && !f_in_ready);
endmodule // stdd_top
`default_nettype wire

// *** core/stdd_pkg.sv ***
// Shared constants and carriers for the split descriptor decoder
`default_nettype none
package stdd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_PUSH   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LAST   = 8'h08;
    localparam logic [7:0] OFS_CTRL   = 8'h0c;
    // First word (bits 31:0)
    localparam int ACT_BIT = 0;
    localparam int TOT_LSB = 3;
    localparam int MPL_LSB = 18;
    localparam int EP0_BIT = 31;
    // Second word (descriptor bits 63:32, held at bit - 32)
    localparam int EPH_LSB   = 0;
    localparam int SPLIT_BIT = 14;
    localparam int SE_LSB    = 16;
    // Third word (descriptor bits 31:0 of the next pair)
    localparam int IDX_LSB = 8;
    // Speed/end codes for bulk and control splits
    localparam logic [1:0] SE_LOW  = 2'h2;
    localparam logic [1:0] SE_FULL = 2'h0;
    // Index of the last of the three words that make up one descriptor
    localparam logic [1:0] LAST_WORD = 2'h2;
    // Largest legal packet for a full-speed target
    localparam logic [10:0] FS_MAX_PKT = 11'h040;
    // Reset values
    localparam logic       CTRL_EN_RST = 1'b1;
    localparam logic [7:0] SKIP_RST    = 8'h00;

    typedef struct packed {
        logic [3:0]  ep;
        logic [10:0] max_pkt;
        logic [14:0] total;
        logic        split;
        logic        low_speed;
        logic [15:0] mem_index;
    } stdd_xfer_s;

    typedef struct packed {
        logic [31:0] dw2;
        logic [31:0] dw1;
        logic [31:0] dw0;
    } stdd_desc_s;
endpackage
`default_nettype wire

// *** tb/stdd_exec_model.sv ***
// Far-side executor model: answers each issued transfer after a set lag
`default_nettype none

module stdd_exec_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       xfer_start,
    input  wire logic       fail_mode,
    input  wire logic [3:0] lag,
    output logic            xfer_done,
    output logic            xfer_fatal
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       busy;
    logic [3:0] cnt;

    // One transfer at a time; a lag of zero answers two cycles after the start cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy       <= 1'b0;
            cnt        <= 4'h0;
            xfer_done  <= 1'b0;
            xfer_fatal <= 1'b0;
        end else begin
            xfer_done  <= 1'b0;
            xfer_fatal <= 1'b0;
            if (xfer_start) begin
                busy <= 1'b1;
                cnt  <= lag;
            end else if (busy && cnt == 4'h0) begin
                busy       <= 1'b0;
                xfer_done  <= ~fail_mode;
                xfer_fatal <= fail_mode;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule // stdd_exec_model

`default_nettype wire

// *** tb/stdd_top_tb.sv ***
// Testbench for the split descriptor decoder: bus tasks and scenarios
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end

module stdd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import stdd_pkg::*;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rdy_s;
    logic        xfer_start, xfer_done, xfer_fatal, fail_mode, sp;
    logic [31:0] haddr, hwdata, hrdata, rd_s, rv;
    logic [1:0]  htrans, se;
    logic [2:0]  hsize;
    logic [3:0]  lag, ep;
    logic [10:0] mpl;
    logic [14:0] tot;
    logic [15:0] ix;
    stdd_xfer_s  xfer, exp_x;
    stdd_desc_s  d;
    int          n_fail = 0, cmp_count = 0, n_start = 0, ns, k;

    stdd_top #(.FIFO_DEPTH(16)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .xfer_start(xfer_start), .xfer(xfer),
        .xfer_done(xfer_done), .xfer_fatal(xfer_fatal));

    stdd_exec_model exec_u (
        .hclk(hclk), .hresetn(hresetn), .xfer_start(xfer_start),
        .fail_mode(fail_mode), .lag(lag), .xfer_done(xfer_done),
        .xfer_fatal(xfer_fatal));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // Values as sampled at the last rising edge, free of update races
    always @(posedge hclk) begin
        rdy_s <= hreadyout;
        rd_s  <= hrdata;
        if (xfer_start === 1'b1) n_start <= n_start + 1;
    end

    task automatic report_and_stop;
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick;
        @(posedge hclk);
        #1;
    endtask

    task automatic wait_rdy;
        for (int i = 0; i < 200; i++) begin
            tick();
            if (rdy_s === 1'b1) return;
        end
        n_fail++;
        report_and_stop();
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rv = rd_s;
    endtask

    task automatic push3(input stdd_desc_s x);
        bus(1'b1, OFS_PUSH, x.dw0);
        bus(1'b1, OFS_PUSH, x.dw1);
        bus(1'b1, OFS_PUSH, x.dw2);
    endtask

    // Polls until the FIFO is empty and the decoder has gone idle
    task automatic wait_idle;
        for (int i = 0; i < 60; i++) begin
            bus(1'b0, OFS_STATUS, 32'h0);
            if (rv[5] === 1'b0 && rv[4:0] === 5'h00) return;
        end
        n_fail++;
        report_and_stop();
    endtask

    task automatic wait_start(input int target);
        for (int i = 0; i < 500; i++) begin
            tick();
            if (n_start >= target) return;
        end
        n_fail++;
        report_and_stop();
    endtask

    function automatic stdd_desc_s mk(input logic act);
        mk = '0;
        mk.dw0 = {ep[0], 2'h0, mpl, tot, 2'h0, act};
        mk.dw1[2:0]   = ep[3:1];
        mk.dw1[14]    = sp;
        mk.dw1[17:16] = se;
        mk.dw2[23:8]  = ix;
    endfunction

    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, fail_mode} = '0;
        hsize = 3'h2;
        lag   = 4'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        tick();
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(rv, 32'h0)
        `CHK(hresp, 1'b0)
        bus(1'b0, OFS_CTRL, 32'h0);
        `CHK(rv[0], CTRL_EN_RST)
        bus(1'b0, 8'h10, 32'h0);
        `CHK(rv, 32'h0)
        // Low split, full split at 64, plain high speed, fatal full split
        for (k = 0; k < 4; k++) begin
            fail_mode <= (k == 3);
            lag <= 4'(k);
            ep  = 4'h9 + 4'(k);
            mpl = (k == 2) ? 11'h400 : (k == 1) ? 11'h040 : 11'h020;
            tot = 15'h7fff - 15'(k);
            sp  = (k != 2);
            se  = (k == 1 || k == 3) ? SE_FULL : SE_LOW;
            ix  = 16'((32'h800 - 32'h400) >> 3) + 16'(k);
            d   = mk(1'b1);
            ns  = n_start;
            push3(d);
            wait_start(ns + 1);
            exp_x = '{ep, mpl, tot, sp, sp && (se == SE_LOW), ix};
            `CHK(xfer, exp_x)
            wait_idle();
            `CHK(rv[7], 1'(k == 3))
            `CHK(rv[6], 1'b0)
            bus(1'b0, OFS_LAST, 32'h0);
            `CHK(rv, d.dw0 & ~32'h1)
        end
        // Inactive descriptor must be skipped without an issue
        d  = mk(1'b0);
        ns = n_start;
        push3(d);
        wait_idle();
        `CHK(rv[15:8], 8'h01)
        `CHK(n_start, ns)
        bus(1'b0, OFS_LAST, 32'h0);
        `CHK(rv, d.dw0)
        // Hold decode off, stack five descriptors, then drain slowly
        bus(1'b1, OFS_CTRL, 32'h0);
        lag <= 4'h9;
        fail_mode <= 1'b0;
        for (k = 0; k < 5; k++) push3(mk(1'b1));
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(rv[4:0], 5'h0f)
        `CHK(n_start, ns)
        bus(1'b1, OFS_CTRL, 32'h1);
        wait_start(ns + 5);
        wait_idle();
        `CHK(n_start, ns + 5)
        report_and_stop();
    end
endmodule // stdd_top_tb

`default_nettype wire
